// >>> src/uie_pkg.sv
/*
  Shared constants for the USB interrupt enable and error status block:
  register offsets, field positions, reset values and widths.
  Assumes a 32-bit APB master with byte addresses and aligned words.
*/
package uie_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned FLAG_W       = 8;
  localparam int unsigned SIZE_W       = 10;
  localparam int unsigned COUNT_W      = 11;

  localparam logic [11:0] OFS_IRQ_EN   = 12'h000;
  localparam logic [11:0] OFS_ERR_STAT = 12'h004;
  localparam logic [11:0] OFS_ERR_EN   = 12'h008;
  localparam logic [11:0] OFS_EVT_STAT = 12'h00C;
  localparam logic [11:0] OFS_BUF_SIZE = 12'h010;

  // Enable and event flag positions
  localparam int unsigned BIT_STALL    = 7;
  localparam int unsigned BIT_ATTACH   = 6;
  localparam int unsigned BIT_RESUME   = 5;
  localparam int unsigned BIT_IDLE     = 4;
  localparam int unsigned BIT_TOKEN    = 3;
  localparam int unsigned BIT_SOF      = 2;
  localparam int unsigned BIT_ERRSUM   = 1;
  localparam int unsigned BIT_RST_DET  = 0;

  // Error flag positions
  localparam int unsigned BIT_STUFF    = 7;
  localparam int unsigned BIT_ERR_RSVD = 6;
  localparam int unsigned BIT_DMA      = 5;
  localparam int unsigned BIT_TURN     = 4;
  localparam int unsigned BIT_FIELD    = 3;
  localparam int unsigned BIT_DCRC     = 2;
  localparam int unsigned BIT_TCRC_EOF = 1;
  localparam int unsigned BIT_PID      = 0;

  localparam logic [7:0]  RST_IRQ_EN   = 8'h00;
  localparam logic [7:0]  RST_ERR_STAT = 8'h00;
  localparam logic [7:0]  RST_ERR_EN   = 8'h00;
  localparam logic [7:0]  RST_EVT_STAT = 8'h00;
  localparam logic [9:0]  RST_BUF_SIZE = 10'h040;
  localparam logic [7:0]  ERR_IMPL     = 8'hBF;

endpackage

// >>> src/uie_rx_limit.sv
/*
  Received byte limiter: passes bytes of one packet until the programmed
  buffer size is reached, drops the rest and pulses an overflow.
  Assumes start pulses once before the first byte of each packet.
*/
`timescale 1ns/1ps
`default_nettype none

module uie_rx_limit
  import uie_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              start_in,
  input  wire logic              valid_in,
  input  wire logic [7:0]        data_in,
  input  wire logic [SIZE_W-1:0] size_in,
  output logic                   store_out,
  output logic      [7:0]        data_out,
  output logic                   overflow_out
);

  logic [COUNT_W-1:0] count_q;
  logic               room;

  assign room = (count_q < {1'b0, size_in});

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_q <= '0;
    else if (start_in)
      count_q <= '0;
    else if (valid_in && room)
      count_q <= count_q + COUNT_W'(1);
  end

  // Bytes past the buffer size are not stored
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      store_out    <= 1'b0;
      data_out     <= 8'h00;
      overflow_out <= 1'b0;
    end
    else
    begin
      store_out    <= valid_in && room && !start_in;
      data_out     <= data_in;
      overflow_out <= valid_in && !room && !start_in;
    end
  end

endmodule

`default_nettype wire

// >>> src/uie_top.sv
/*
  USB interrupt enable and error status registers behind an APB slave,
  with role dependent flag meanings and a receive size limiter.
  Assumes event and error inputs are one-cycle pulses from the protocol
  engine, synchronous to sys_clk_in, and a 32-bit APB master.
*/
// Summary of operation
// - The upper three bytes of the interrupt enable register read zero and ignore writes.
// - Enable bit 7 lets the stall handshake event raise the interrupt.
// - Enable bit 6 lets the attach event raise the interrupt, in host role only.
// - Enable bit 5 lets the resume event raise the interrupt.
// - Enable bit 4 lets the idle detect event raise the interrupt.
// - Enable bit 3 lets the token done event raise the interrupt.
// - Enable bit 2 lets the start of frame event raise the interrupt.
// - Enable bit 1 lets the error summary event raise the interrupt.
// - Enable bit 0 gates bus reset in device role and detach in host role.
// - The error status holds seven flags in its low byte with bit 6 reading zero.
// - Error bit 1 reports token CRC errors in device role and frame end errors in host role.
// - Error flags are set by hardware only, reset to zero and clear on a written one.
// - Bytes beyond the buffer size set the DMA error flag and are not stored.
// - The error summary flag is set only by errors whose error enable bit is one.
`timescale 1ns/1ps
`default_nettype none

module uie_top
  import uie_pkg::*;
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     resetn_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [uie_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [uie_pkg::DATA_W-1:0] pwdata_in,
  output logic      [uie_pkg::DATA_W-1:0] prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic                     host_role_in,
  input  wire logic                     stall_evt_in,
  input  wire logic                     attach_evt_in,
  input  wire logic                     resume_evt_in,
  input  wire logic                     idle_evt_in,
  input  wire logic                     token_done_evt_in,
  input  wire logic                     frame_start_evt_in,
  input  wire logic                     bus_reset_evt_in,
  input  wire logic                     detach_evt_in,
  input  wire logic                     bit_stuff_err_in,
  input  wire logic                     turnaround_timeout_err_in,
  input  wire logic                     field_size_err_in,
  input  wire logic                     data_crc_err_in,
  input  wire logic                     token_crc_err_in,
  input  wire logic                     frame_end_err_in,
  input  wire logic                     packet_id_err_in,
  input  wire logic                     rx_start_in,
  input  wire logic                     rx_valid_in,
  input  wire logic [7:0]               rx_data_in,
  output logic                          rx_store_out,
  output logic      [7:0]               rx_data_out,
  output logic                          irq_out
);

  import uie_pkg::*;

  logic [FLAG_W-1:0] usb_interrupt_enable_q;
  logic [FLAG_W-1:0] usb_error_status_q;
  logic [FLAG_W-1:0] usb_error_status_d;
  logic [FLAG_W-1:0] usb_error_enable_q;
  logic [FLAG_W-1:0] event_status_q;
  logic [FLAG_W-1:0] event_status_d;
  logic [SIZE_W-1:0] buf_size_q;

  logic [FLAG_W-1:0] err_set;
  logic [FLAG_W-1:0] evt_set;
  logic [FLAG_W-1:0] err_clr;
  logic [FLAG_W-1:0] evt_clr;
  logic [FLAG_W-1:0] irq_terms;
  logic              error_summary_flag;
  logic              dma_overflow_err;

  logic              access;
  logic              wr_commit;
  logic              addr_ok;
  logic              sel_irq_en;
  logic              sel_err_stat;
  logic              sel_err_en;
  logic              sel_evt_stat;
  logic              sel_buf_size;
  logic [DATA_W-1:0] rdata_d;
  logic              pready_q;
  logic [DATA_W-1:0] prdata_q;
  logic              pslverr_q;
  logic              irq_q;

  // Bus decode
  assign access       = psel_in && penable_in;
  assign wr_commit    = access && pwrite_in && pready_q;
  assign sel_irq_en   = (paddr_in == OFS_IRQ_EN);
  assign sel_err_stat = (paddr_in == OFS_ERR_STAT);
  assign sel_err_en   = (paddr_in == OFS_ERR_EN);
  assign sel_evt_stat = (paddr_in == OFS_EVT_STAT);
  assign sel_buf_size = (paddr_in == OFS_BUF_SIZE);
  assign addr_ok      = sel_irq_en || sel_err_stat || sel_err_en || sel_evt_stat || sel_buf_size;

  // One wait state, then answer
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pready_q <= 1'b0;
    else
      pready_q <= access && !pready_q;
  end

  always_comb
  begin
    rdata_d = '0;
    case (1'b1)
      sel_irq_en:   rdata_d = {24'h000000, usb_interrupt_enable_q};
      sel_err_stat: rdata_d = {24'h000000, usb_error_status_q & ERR_IMPL};
      sel_err_en:   rdata_d = {24'h000000, usb_error_enable_q & ERR_IMPL};
      sel_evt_stat: rdata_d = {24'h000000, event_status_q};
      sel_buf_size: rdata_d = {22'h000000, buf_size_q};
      default:      rdata_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else if (access && !pready_q)
    begin
      prdata_q  <= pwrite_in ? '0 : rdata_d;
      pslverr_q <= !addr_ok;
    end
    else
    begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
  end

  assign pready_out  = pready_q;
  assign prdata_out  = prdata_q;
  assign pslverr_out = pslverr_q;

  // Interrupt enable, upper three bytes not stored
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      usb_interrupt_enable_q <= RST_IRQ_EN;
    else if (wr_commit && sel_irq_en)
      usb_interrupt_enable_q <= pwdata_in[FLAG_W-1:0];
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      usb_error_enable_q <= RST_ERR_EN;
    else if (wr_commit && sel_err_en)
      usb_error_enable_q <= pwdata_in[FLAG_W-1:0] & ERR_IMPL;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      buf_size_q <= RST_BUF_SIZE;
    else if (wr_commit && sel_buf_size)
      buf_size_q <= pwdata_in[SIZE_W-1:0];
  end

  // Receive size limiter
  uie_rx_limit u_rx_limit
  (
    .clk_in       (sys_clk_in),
    .resetn_in    (resetn_in),
    .start_in     (rx_start_in),
    .valid_in     (rx_valid_in),
    .data_in      (rx_data_in),
    .size_in      (buf_size_q),
    .store_out    (rx_store_out),
    .data_out     (rx_data_out),
    .overflow_out (dma_overflow_err)
  );

  // Hardware error sets
  always_comb
  begin
    err_set               = '0;
    err_set[BIT_STUFF]    = bit_stuff_err_in;
    err_set[BIT_ERR_RSVD] = 1'b0;
    err_set[BIT_DMA]      = dma_overflow_err;
    err_set[BIT_TURN]     = turnaround_timeout_err_in;
    err_set[BIT_FIELD]    = field_size_err_in;
    err_set[BIT_DCRC]     = data_crc_err_in;
    err_set[BIT_PID]      = packet_id_err_in;
    if (host_role_in)
      err_set[BIT_TCRC_EOF] = frame_end_err_in;
    else
      err_set[BIT_TCRC_EOF] = token_crc_err_in;
  end

  // Only enabled errors feed the summary
  assign error_summary_flag = |(err_set & usb_error_enable_q);

  assign err_clr = (wr_commit && sel_err_stat) ? pwdata_in[FLAG_W-1:0] : '0;

  always_comb
  begin
    usb_error_status_d = (usb_error_status_q & ~err_clr) | err_set;
    usb_error_status_d = usb_error_status_d & ERR_IMPL;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      usb_error_status_q <= RST_ERR_STAT;
    else
      usb_error_status_q <= usb_error_status_d;
  end

  // Hardware event sets
  always_comb
  begin
    evt_set              = '0;
    evt_set[BIT_STALL]   = stall_evt_in;
    evt_set[BIT_ATTACH]  = attach_evt_in && host_role_in;
    evt_set[BIT_RESUME]  = resume_evt_in;
    evt_set[BIT_IDLE]    = idle_evt_in;
    evt_set[BIT_TOKEN]   = token_done_evt_in;
    evt_set[BIT_SOF]     = frame_start_evt_in;
    evt_set[BIT_ERRSUM]  = error_summary_flag;
    if (host_role_in)
      evt_set[BIT_RST_DET] = detach_evt_in;
    else
      evt_set[BIT_RST_DET] = bus_reset_evt_in;
  end

  assign evt_clr = (wr_commit && sel_evt_stat) ? pwdata_in[FLAG_W-1:0] : '0;

  always_comb
  begin
    event_status_d = (event_status_q & ~evt_clr) | evt_set;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      event_status_q <= RST_EVT_STAT;
    else
      event_status_q <= event_status_d;
  end

  // Per source gating onto the request
  always_comb
  begin
    irq_terms              = '0;
    irq_terms[BIT_STALL]   = event_status_q[BIT_STALL] && usb_interrupt_enable_q[BIT_STALL];
    irq_terms[BIT_ATTACH]  = event_status_q[BIT_ATTACH] && usb_interrupt_enable_q[BIT_ATTACH]
                             && host_role_in;
    irq_terms[BIT_RESUME]  = event_status_q[BIT_RESUME] && usb_interrupt_enable_q[BIT_RESUME];
    irq_terms[BIT_IDLE]    = event_status_q[BIT_IDLE] && usb_interrupt_enable_q[BIT_IDLE];
    irq_terms[BIT_TOKEN]   = event_status_q[BIT_TOKEN] && usb_interrupt_enable_q[BIT_TOKEN];
    irq_terms[BIT_SOF]     = event_status_q[BIT_SOF] && usb_interrupt_enable_q[BIT_SOF];
    irq_terms[BIT_ERRSUM]  = event_status_q[BIT_ERRSUM] && usb_interrupt_enable_q[BIT_ERRSUM];
    irq_terms[BIT_RST_DET] = event_status_q[BIT_RST_DET] && usb_interrupt_enable_q[BIT_RST_DET];
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      irq_q <= 1'b0;
    else
      irq_q <= |irq_terms;
  end

  assign irq_out = irq_q;

endmodule

`default_nettype wire

// >>> verification/uie_monitor.sv
/* Port checker for uie_top, bound after the module.
   Assumes enables stay put while an event is in flight. */
`timescale 1ns/1ps
`default_nettype none
module uie_monitor
  import uie_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              resetn_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [DATA_W-1:0] pwdata_in,
  input wire logic [DATA_W-1:0] prdata_out,
  input wire logic              pready_out,
  input wire logic              host_role_in,
  input wire logic              stall_evt_in,
  input wire logic              bus_reset_evt_in,
  input wire logic              data_crc_err_in,
  input wire logic              rx_valid_in,
  input wire logic [7:0]        rx_data_in,
  input wire logic              rx_store_out,
  input wire logic [7:0]        rx_data_out,
  input wire logic              irq_out
);
  logic [7:0] en_q, een_q;
  logic       wr;
  logic       rd;
  assign wr = psel_in & penable_in & pready_out & pwrite_in;
  assign rd = pready_out & !pwrite_in;
  // Shadows of the two enable registers
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) en_q <= RST_IRQ_EN;
    else if (wr && paddr_in == OFS_IRQ_EN) en_q <= pwdata_in[7:0];
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in) een_q <= RST_ERR_EN;
    else if (wr && paddr_in == OFS_ERR_EN) een_q <= pwdata_in[7:0];
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  a_upper_zero: assert property (rd |-> prdata_out[31:8] == 24'h000000)
    else $error("upper bits set");
  a_enable_back: assert property (rd && paddr_in == OFS_IRQ_EN |-> prdata_out[7:0] == en_q)
    else $error("enable readback");
  a_err_gap: assert property (rd && paddr_in == OFS_ERR_STAT |-> !prdata_out[BIT_ERR_RSVD])
    else $error("error bit 6 set");
  a_stall_irq: assert property (stall_evt_in && en_q[BIT_STALL] |=> ##1 irq_out)
    else $error("stall irq missing");
  a_reset_irq: assert property (bus_reset_evt_in && !host_role_in && en_q[0] |=> ##1 irq_out)
    else $error("bus reset irq missing");
  a_sum_irq: assert property (data_crc_err_in && een_q[2] && en_q[1] |=> ##1 irq_out)
    else $error("summary irq missing");
  a_mask_all: assert property ((en_q == 8'h00) [*2] |-> !irq_out)
    else $error("irq while masked");
  a_rx_echo: assert property (rx_store_out |-> $past(rx_valid_in) && rx_data_out == $past(rx_data_in))
    else $error("stored byte wrong");
endmodule
bind uie_top uie_monitor uie_monitor_inst (.sys_clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .host_role_in, .stall_evt_in, .bus_reset_evt_in,
  .data_crc_err_in, .rx_valid_in, .rx_data_in, .rx_store_out, .rx_data_out, .irq_out);
`default_nettype wire

// >>> verification/uie_engine_model.sv
/* Protocol engine model: turns a requested vector into one-cycle
   event and error pulses. Driven by the bench. */
`timescale 1ns/1ps
`default_nettype none
module uie_engine_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       go_in,
  input  wire logic [8:0] ev_in,
  input  wire logic [8:0] er_in,
  output logic      [8:0] ev_out,
  output logic      [8:0] er_out
);
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in) {ev_out, er_out} <= 18'h00000;
    else {ev_out, er_out} <= go_in ? {ev_in, er_in} : 18'h00000;
endmodule
`default_nettype wire

// >>> verification/uie_top_test.sv
/* Self-checking bench for uie_top: APB master, engine model, rx feed.
   Assumes the package, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uie_top_test;
  import uie_pkg::*;
  logic        clk, rstn, psel, pen, pwr, hr, go, rxs, rxv, rdy, serr, irq, sto, se;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r, seed, x;
  logic [8:0]  ev, er, evp, erp;
  logic [7:0]  rxd, rxo, e8, st[$], sent[$];
  int          error_cnt, n_checks, i, k;
  uie_top uie_top_inst (.sys_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
    .host_role_in(hr), .stall_evt_in(evp[7]), .attach_evt_in(evp[6]), .resume_evt_in(evp[5]),
    .idle_evt_in(evp[4]), .token_done_evt_in(evp[3]), .frame_start_evt_in(evp[2]),
    .bus_reset_evt_in(evp[0]), .detach_evt_in(evp[8]), .bit_stuff_err_in(erp[7]),
    .turnaround_timeout_err_in(erp[4]), .field_size_err_in(erp[3]), .data_crc_err_in(erp[2]),
    .token_crc_err_in(erp[1]), .frame_end_err_in(erp[8]), .packet_id_err_in(erp[0]), .rx_start_in(rxs),
    .rx_valid_in(rxv), .rx_data_in(rxd), .rx_store_out(sto), .rx_data_out(rxo), .irq_out(irq));
  uie_engine_model uie_engine_model_inst (.clk_in(clk), .resetn_in(rstn), .go_in(go), .ev_in(ev),
    .er_in(er), .ev_out(evp), .er_out(erp));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (sto === 1'b1) st.push_back(rxo);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bit 1 follows role, DMA and bit 6 never come from the engine
  function automatic logic [7:0] exp_err(input logic [8:0] e, input logic h);
    return {e[7], 2'b00, e[4:2], h ? e[8] : e[1], e[0]};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    n_checks++;
    if (g !== w)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
    {r, se} = {prd, serr};
    {psel, pen} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [8:0] v, input logic [8:0] w);
    @(posedge clk);
    {ev, er, go} <= {v, w, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    #1000000;
    error_cnt++;
    close_out();
  end
  initial
  begin
    {rstn, psel, pen, pwr, hr, go, rxs, rxv, pa, pwd, ev, er, rxd} = '0;
    {seed, error_cnt, n_checks} = {32'h040D, 64'h0};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_ERR_STAT);
    chk(r, 32'h0);
    rd(OFS_BUF_SIZE);
    chk(r, {22'h0, RST_BUF_SIZE});
    apb(1'b1, OFS_IRQ_EN, 32'hFFFFFFFF);
    rd(OFS_IRQ_EN);
    chk(r, 32'hFF);
    rd(12'h014);
    chk(r, 32'h0);
    chk({31'h0, se}, 32'h1);
    apb(1'b1, OFS_ERR_EN, 32'hFF);
    $display("registers done");
    for (i = 0; i < 9; i++)
    begin
      k = (i == 8) ? 0 : i;
      hr <= (i == 6 || i == 8);
      apb(1'b1, OFS_IRQ_EN, 32'h1 << k);
      pulse(i == 1 ? 9'h0 : 9'h1 << i, i == 1 ? 9'h4 : 9'h0);
      chk(irq, 32'h1);
      rd(OFS_EVT_STAT);
      chk(r, 32'h1 << k);
      apb(1'b1, OFS_IRQ_EN, ~(32'h1 << k) & 32'hFF);
      rd(OFS_IRQ_EN);
      chk(irq, 32'h0);
      apb(1'b1, OFS_EVT_STAT, 32'hFF);
      apb(1'b1, OFS_ERR_STAT, 32'hFF);
      if (k == 0 || i == 6)
      begin
        hr <= ~hr;
        pulse(9'h1 << i, 9'h0);
        rd(OFS_EVT_STAT);
        chk(r, 32'h0);
      end
    end
    $display("events done");
    // All flags but attach up with every interrupt enable off
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    pulse(9'h1FF, 9'h004);
    chk(irq, 32'h0);
    apb(1'b1, OFS_EVT_STAT, 32'hFF);
    apb(1'b1, OFS_ERR_STAT, 32'hFF);
    apb(1'b1, OFS_IRQ_EN, 32'h2);
    repeat (8)
    begin
      x = rnd();
      hr <= x[20];
      apb(1'b1, OFS_ERR_EN, {24'h0, x[7:0]});
      pulse(9'h0, x[16:8] & 9'h19F);
      e8 = exp_err(x[16:8] & 9'h19F, hr);
      rd(OFS_ERR_STAT);
      chk(r, {24'h0, e8});
      rd(OFS_EVT_STAT);
      chk(r[1], |(e8 & x[7:0]));
      apb(1'b1, OFS_ERR_STAT, {24'hFFFFFF, x[31:24]});
      rd(OFS_ERR_STAT);
      chk(r, {24'h0, e8 & ~x[31:24]});
      apb(1'b1, OFS_ERR_STAT, 32'hFF);
      apb(1'b1, OFS_EVT_STAT, 32'hFF);
    end
    $display("errors done");
    apb(1'b1, OFS_BUF_SIZE, 32'h4);
    rxs <= 1'b1;
    @(posedge clk);
    rxs <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      x = rnd();
      {rxv, rxd} <= {1'b1, x[7:0]};
      sent.push_back(x[7:0]);
      @(posedge clk);
    end
    rxv <= 1'b0;
    repeat (4) @(posedge clk);
    chk(st.size(), 32'h4);
    for (i = 0; i < 4; i++) chk(st[i], sent[i]);
    rd(OFS_ERR_STAT);
    chk(r[BIT_DMA], 32'h1);
    $display("receive done");
    // Reset in mid-run with the DMA flag standing
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(OFS_ERR_STAT);
    chk(r, 32'h0);
    chk(irq, 32'h0);
    $display("reset done");
    close_out();
  end
endmodule
`default_nettype wire
